// file: core/rx_rate_cdr_ctrl.v
// receiver rate select, clock-recovery control and parallel divider selection
// assumes a classic wishbone master on clk_i, rate select synchronous to clk_i
//
// How it works
// R01: fabric inverts equalizer mode bit to switch
// R02: fabric then pulses analog reset
// R03: rate code picks serial divider value
// R04: freeze stops loop tracking updates
// R05: frequency detector reset clears frequency state
// R06: phase detector reset clears phase state
// R07: hold-on-idle keeps loop state in idle
// R08: freq-reset-on-idle resets frequency during idle
// R09: phase-reset-on-idle resets phase during idle
// R10: fabric width picks divide by four/five
// R11: internal width picks divide by two/four
// R12: fixed rate uses static divider, code zero
// R13: configured code matches static divider
// R14: nonzero code overrides static divider dynamically
// R15: optional elastic buffer reset on change
// R16: done pulse one cycle after delay
// R17: eight-bit delay sets done timing
// R18: code seven acts as divide by one
//
// the rate code is taken as synchronous to clk_i, which stands for the
// receive user clock; no synchroniser sits in front of it
// the detector resets arrive as control register bits, not as pins, so
// they act on the next clock rather than at once; software that needs
// them must write the control word and clear it again
// the equalizer mode switch is a software sequence: flip the mode bit,
// then raise and clear the analog reset bit
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rx_rate_cdr_regs.vh"

module rx_rate_cdr_ctrl
(
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // fabric controls
    input  wire [2:0]  rx_rate_select_i,
    input  wire        electrical_idle_i,
    // controls toward the analog receiver
    output reg         lpm_mode_select_o,
    output reg         rx_analog_reset_o,
    output reg         cdr_track_enable_o,
    output reg         cdr_freq_state_reset_o,
    output reg         cdr_phase_state_reset_o,
    output reg  [4:0]  serial_divider_o,
    output reg  [2:0]  parallel_divider_a_o,
    output reg  [2:0]  parallel_divider_b_o,
    output reg         elastic_buffer_reset_o,
    output reg         rate_change_done_o
);

    // register map, byte addresses on the wishbone port
    //   0x00 control, read/write
    //     [0] equalizer mode select, passed to the analog receiver
    //     [1] analog receiver reset, a level held until software clears it
    //     [2] freeze the recovery loop tracking
    //     [3] frequency detector reset
    //     [4] phase detector reset
    //     [5] hold loop state while the line is idle
    //     [6] reset frequency state while the line is idle
    //     [7] reset phase state while the line is idle
    //     [8] pulse the elastic buffer reset on a rate change
    //     [9] internal path width, 0 two bytes, 1 four bytes
    //   0x04 rate setup, read/write
    //     [4:0]   static serial divider, used while the rate code is zero
    //     [15:8]  wait from a rate change to the done pulse, in clocks beyond the first three
    //     [22:16] fabric data width in bits
    //   0x08 status, read only; any write clears the done flag
    //     [2:0] rate code now on the input
    //     [4]   rate change wait in progress
    //     [5]   done seen since the last clear; a new pulse beats the clear
    //   0x0c dividers, read only: [4:0] serial, [7:5] fabric, [10:8] internal
    //   other addresses read as zero and ignore writes
    // outputs toward the analog side are all registered and follow the
    // control word one clock after a write lands

    // serial divider from rate code and static setting
    function [4:0] serial_div;
        input [2:0] code;
        input [4:0] static_div;
        begin
            case (code)
                `RATE_STATIC: serial_div = static_div;   // see R03, R12
                `RATE_DIV1:   serial_div = 5'h01;        // see R03
                `RATE_DIV2:   serial_div = 5'h02;
                `RATE_DIV4:   serial_div = 5'h04;
                `RATE_DIV8:   serial_div = 5'h08;
                `RATE_DIV16:  serial_div = 5'h10;
                `RATE_DIV1_ALT: serial_div = 5'h01;
                default:      serial_div = 5'h01;        // see R18
            endcase
        end
    endfunction

    // register decode, shared by the write, read and status-clear paths
    function reg_hit;
        input [7:0] adr;
        input [7:0] offset;
        begin
            reg_hit = (adr == offset);
        end
    endfunction

    // fabric widths of 20, 40 or 80 bits need the divide-by-five stage
    function fabric_div5;
        input [6:0] width;
        begin
            fabric_div5 = (width == 7'h14) || (width == 7'h28) || (width == 7'h50);
        end
    endfunction

    // sequencer states: idle until a change, then counting down the delay
    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    reg  [9:0] ctrl_q;
    reg  [4:0] static_div_q;
    reg  [7:0] delay_q;
    reg  [6:0] fabric_w_q;
    reg  [2:0] rate_prev_q;
    reg  [7:0] count_q;
    reg        state_q;
    reg        change_seen_q;
    reg        done_sticky_q;

    wire       access     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wr         = access & wb_we_i;
    wire       rate_moved = (rx_rate_select_i != rate_prev_q);   // see R14

    // address hits, qualified by the bus cycle below
    wire       hit_ctrl   = reg_hit(wb_adr_i, `REG_CTRL);
    wire       hit_rate   = reg_hit(wb_adr_i, `REG_RATE);
    wire       hit_status = reg_hit(wb_adr_i, `REG_STATUS);
    wire       hit_div    = reg_hit(wb_adr_i, `REG_DIVIDERS);

    // bus slave: single wait-free answer one cycle after the request
    // a request is taken on the edge where cyc and stb are high and ack is low;
    // writes land on that edge and ack with read data follows one clock later,
    // so a master never waits more than one cycle and ack never lasts two
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= 32'h0000_0000;
            ctrl_q       <= `CTRL_RESET;
            static_div_q <= `STATIC_DIV_RESET;
            delay_q      <= `DELAY_RESET;
            fabric_w_q   <= `FABRIC_W_RESET;
        end
        else
        begin
            wb_ack_o <= access;
            wb_dat_o <= 32'h0000_0000;
            // byte lanes guard each field so a partial write leaves the others
            if (wr && hit_ctrl)
            begin
                if (wb_sel_i[0])
                    ctrl_q[7:0] <= wb_dat_i[7:0];    // see R01, R02
                if (wb_sel_i[1])
                    ctrl_q[9:8] <= wb_dat_i[9:8];
            end
            else if (wr && hit_rate)
            begin
                if (wb_sel_i[0])
                    static_div_q <= wb_dat_i[4:0];
                if (wb_sel_i[1])
                    delay_q <= wb_dat_i[15:8];       // see R17
                if (wb_sel_i[2])
                    fabric_w_q <= wb_dat_i[22:16];
            end
            // read data is registered and stands only in the ack cycle
            if (access && !wb_we_i)
            begin
                if (hit_ctrl)
                    wb_dat_o <= {22'h000000, ctrl_q};
                else if (hit_rate)
                    wb_dat_o <= {9'h000, fabric_w_q, delay_q, 3'h0, static_div_q};
                else if (hit_status)
                    wb_dat_o <= {26'h0000000, done_sticky_q, state_q,
                                 1'b0, rx_rate_select_i};
                else if (hit_div)
                    wb_dat_o <= {21'h000000, parallel_divider_b_o,
                                 parallel_divider_a_o, serial_divider_o};
                else
                    wb_dat_o <= 32'h0000_0000;       // unmapped reads zero
            end
        end
    end

    // clock-recovery and equalizer controls, idle behaviour
    // the detector resets are taken as synchronous levels; software raises
    // and clears them, so each lasts at least from one bus write to the next
    // the idle options only act while the idle input is high
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lpm_mode_select_o       <= 1'b0;
            rx_analog_reset_o       <= 1'b0;
            cdr_track_enable_o      <= 1'b1;
            cdr_freq_state_reset_o  <= 1'b0;
            cdr_phase_state_reset_o <= 1'b0;
        end
        else
        begin
            lpm_mode_select_o  <= ctrl_q[`CTRL_LPM_BIT];
            rx_analog_reset_o  <= ctrl_q[`CTRL_AN_RST_BIT];
            cdr_track_enable_o <= ~ctrl_q[`CTRL_FREEZE_BIT]                    // see R04
                                  & ~(electrical_idle_i & ctrl_q[`CTRL_HOLD_IDLE_BIT]); // see R07
            cdr_freq_state_reset_o <= ctrl_q[`CTRL_FD_RST_BIT]                 // see R05
                                  | (electrical_idle_i & ctrl_q[`CTRL_FR_IDLE_BIT]);    // see R08
            cdr_phase_state_reset_o <= ctrl_q[`CTRL_PD_RST_BIT]                // see R06
                                  | (electrical_idle_i & ctrl_q[`CTRL_PH_IDLE_BIT]);    // see R09
        end
    end

    // divider selection
    // the dividers are recomputed every clock, so a new code or width shows
    // one clock later with no glitch between two settings
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            serial_divider_o     <= 5'h01;
            parallel_divider_a_o <= 3'h4;
            parallel_divider_b_o <= 3'h2;
        end
        else
        begin
            serial_divider_o <= serial_div(rx_rate_select_i, static_div_q); // see R14
            if (fabric_div5(fabric_w_q))
                parallel_divider_a_o <= 3'h5;        // see R10
            else
                parallel_divider_a_o <= 3'h4;        // see R10
            parallel_divider_b_o <= ctrl_q[`CTRL_INT_W_BIT] ? 3'h4 : 3'h2; // see R11
        end
    end

    // rate change sequencer: buffer reset then timed done pulse
    // timing, with E the edge at which a new rate code is first seen:
    //   E+1  divider and optional buffer reset follow the new code
    //   E+2  the wait counter is loaded from the delay field
    //   E+3+delay  the done pulse stands for one clock
    // a further change while waiting reloads the counter, so only the last
    // change of a burst is answered; a delay of zero still gives a pulse
    // three clocks after the change
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rate_prev_q            <= 3'h0;
            count_q                <= 8'h00;
            state_q                <= ST_IDLE;
            change_seen_q          <= 1'b0;
            elastic_buffer_reset_o <= 1'b0;
            rate_change_done_o     <= 1'b0;
            done_sticky_q          <= 1'b0;
        end
        else
        begin
            rate_prev_q            <= rx_rate_select_i;
            change_seen_q          <= rate_moved;
            rate_change_done_o     <= 1'b0;
            elastic_buffer_reset_o <= rate_moved & ctrl_q[`CTRL_BUF_RST_BIT]; // see R15
            // sticky done flag for software; a pulse in the clearing cycle wins
            if (rate_change_done_o)
                done_sticky_q <= 1'b1;
            else if (wr && hit_status)
                done_sticky_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (change_seen_q)
                    begin
                        count_q <= delay_q;
                        state_q <= ST_WAIT;
                    end
                end
                default:
                begin
                    if (change_seen_q)
                        count_q <= delay_q;          // a new change restarts the wait
                    else if (count_q == 8'h00)
                    begin
                        rate_change_done_o <= 1'b1;  // see R16
                        state_q            <= ST_IDLE;
                    end
                    else
                        count_q <= count_q - 8'h01;  // see R17
                end
            endcase
        end
    end

endmodule // rx_rate_cdr_ctrl
`default_nettype wire

// file: shared/rx_rate_cdr_regs.vh
// constants for the receiver rate and clock-recovery control block
// assumes inclusion by bare name from core files
`ifndef RX_RATE_CDR_REGS_VH
`define RX_RATE_CDR_REGS_VH

// register byte addresses (word aligned)
`define REG_CTRL        8'h00
`define REG_RATE        8'h04
`define REG_STATUS      8'h08
`define REG_DIVIDERS    8'h0c

// control register field positions
`define CTRL_LPM_BIT        0
`define CTRL_AN_RST_BIT     1
`define CTRL_FREEZE_BIT     2
`define CTRL_FD_RST_BIT     3
`define CTRL_PD_RST_BIT     4
`define CTRL_HOLD_IDLE_BIT  5
`define CTRL_FR_IDLE_BIT    6
`define CTRL_PH_IDLE_BIT    7
`define CTRL_BUF_RST_BIT    8
`define CTRL_INT_W_BIT      9

// rate register fields
`define RATE_STATIC_LSB     0
`define RATE_DELAY_LSB      8

// reset values
`define CTRL_RESET          10'h000
`define STATIC_DIV_RESET    5'h01
`define DELAY_RESET         8'h10
`define FABRIC_W_RESET      7'h10

// rate select codes
`define RATE_STATIC     3'h0
`define RATE_DIV1       3'h1
`define RATE_DIV2       3'h2
`define RATE_DIV4       3'h3
`define RATE_DIV8       3'h4
`define RATE_DIV16      3'h5
`define RATE_DIV1_ALT   3'h6

`endif

// file: verif/fabric_model.sv
// fabric model: registers the rate code asked for by the bench
// assumes the block's clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module fabric_model
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] req_i,
    output var  logic [2:0] rate_o = 3'h0
);
    // code zero through reset, so it matches the static divider
    always @(posedge clk_i)
        rate_o <= rst_i ? 3'h0 : req_i;
endmodule // fabric_model
`default_nettype wire

// file: verif/rx_rate_cdr_ctrl_props.sv
// checks on rate decode, change pulses, divider ranges and bus answer
// bound into rx_rate_cdr_ctrl, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module rx_rate_cdr_ctrl_props
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic [2:0] rx_rate_select_i,
    input wire logic [4:0] serial_divider_o,
    input wire logic [2:0] parallel_divider_a_o,
    input wire logic [2:0] parallel_divider_b_o,
    input wire logic       elastic_buffer_reset_o,
    input wire logic       rate_change_done_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    function automatic logic [4:0] div_of(input logic [2:0] c);
        return (c < 3'h6) ? 5'h1 << (c - 3'h1) : 5'h1;
    endfunction
    div_map_a: assert property (rx_rate_select_i != 3'h0 |=>
        serial_divider_o == div_of($past(rx_rate_select_i))) else $error("bad divider");
    buf_pulse_a: assert property (elastic_buffer_reset_o |->
        $past(rx_rate_select_i) != $past(rx_rate_select_i, 2)) else $error("stray reset");
    done_once_a: assert property (rate_change_done_o |=> !rate_change_done_o)
        else $error("long done");
    done_quiet_a: assert property (rate_change_done_o |->
        $past(rx_rate_select_i) == $past(rx_rate_select_i, 3)) else $error("early done");
    fabric_div_a: assert property (parallel_divider_a_o inside {3'h4, 3'h5})
        else $error("bad fabric divider");
    width_div_a: assert property (parallel_divider_b_o inside {3'h2, 3'h4})
        else $error("bad width divider");
    ack_next_a: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    cover property (rate_change_done_o);
    cover property (elastic_buffer_reset_o);
    cover property (parallel_divider_a_o == 3'h5);
endmodule // rx_rate_cdr_ctrl_props
bind rx_rate_cdr_ctrl rx_rate_cdr_ctrl_props i_props (.clk_i, .rst_i, .wb_stb_i, .wb_ack_o,
    .rx_rate_select_i, .serial_divider_o, .parallel_divider_a_o, .parallel_divider_b_o,
    .elastic_buffer_reset_o, .rate_change_done_o);
`default_nettype wire

// file: verif/test_rx_rate_cdr_ctrl.sv
// bench for rx_rate_cdr_ctrl: rate and control rows, then static, timing, reset
// assumes fabric_model and the bound checker compile first
`timescale 1ns/1ps
`default_nettype none
module test_rx_rate_cdr_ctrl;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic electrical_idle_i = 1'b0, wb_ack_o, lpm_mode_select_o, rx_analog_reset_o;
    logic cdr_track_enable_o, cdr_freq_state_reset_o, cdr_phase_state_reset_o;
    logic elastic_buffer_reset_o, rate_change_done_o;
    logic [7:0] wb_adr_i = 8'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [4:0] serial_divider_o;
    logic [2:0] parallel_divider_a_o, parallel_divider_b_o, rx_rate_select_i, req = 3'h0;
    int errors = 0, total_checks = 0, bn, dn, nd;
    // serial divider per code, static divider at 1
    logic [4:0] div_t [8] = '{5'h1, 5'h1, 5'h2, 5'h4, 5'h8, 5'h10, 5'h1, 5'h1};
    // control word, idle; lpm, analog reset, track, freq, phase, wide
    logic [16:0] ctl_t [8] = '{{10'h001, 7'h28}, {10'h003, 7'h38}, {10'h004, 7'h00},
        {10'h018, 7'h0e}, {10'h0e0, 7'h46}, {10'h0e0, 7'h08}, {10'h020, 7'h40}, {10'h200, 7'h09}};
    wire logic [5:0] ctl_seen = {lpm_mode_select_o, rx_analog_reset_o, cdr_track_enable_o,
        cdr_freq_state_reset_o, cdr_phase_state_reset_o, parallel_divider_b_o == 3'h4};
    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;
    // fabric model and the block
    fabric_model i_fab (.clk_i, .rst_i, .req_i(req), .rate_o(rx_rate_select_i));
    rx_rate_cdr_ctrl i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_rate_select_i, .electrical_idle_i,
        .lpm_mode_select_o, .rx_analog_reset_o, .cdr_track_enable_o, .cdr_freq_state_reset_o,
        .cdr_phase_state_reset_o, .serial_divider_o, .parallel_divider_a_o,
        .parallel_divider_b_o, .elastic_buffer_reset_o, .rate_change_done_o);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        errors += (got !== exp);
        if (got !== exp)
            $display("Error at %0t: %h vs %h", $time, got, exp);
    endtask
    // classic cycle held until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic results;
        if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog far past the roughly 150 cycles needed
    initial
    begin
        #20000;
        errors++;
        results();
    end
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            req <= i[2:0];
            repeat (4) @(posedge clk_i);
            check(serial_divider_o, div_t[i]);
        end
        for (int i = 0; i < 8; i++)
        begin
            wb(1'b1, 8'h00, {22'h0, ctl_t[i][16:7]});
            electrical_idle_i <= ctl_t[i][6];
            repeat (3) @(posedge clk_i);
            check(ctl_seen, ctl_t[i][5:0]);
        end
        // code zero, static divider 8, delay 2, fabric width 20
        wb(1'b1, 8'h04, 32'h0014_0208);
        req <= 3'h0;
        repeat (12) @(posedge clk_i);
        check({serial_divider_o, parallel_divider_a_o}, {5'h8, 3'h5});
        wb(1'b0, 8'h0c, 32'h0);
        check(q, 32'h0000_04a8);
        wb(1'b0, 8'h08, 32'h0);
        check(q, 32'h0000_0020);
        wb(1'b1, 8'h08, 32'h0);
        wb(1'b0, 8'h08, 32'h0);
        check(q, 32'h0);
        // rate change with buffer reset off, then on
        for (int k = 0; k < 2; k++)
        begin
            wb(1'b1, 8'h00, {23'h0, k[0], 8'h0});
            req <= k ? 3'h3 : 3'h5;
            {bn, dn, nd} = 0;
            for (int n = 1; n < 12; n++)
            begin
                @(posedge clk_i);
                bn = elastic_buffer_reset_o === 1'b1 ? n : bn;
                dn = rate_change_done_o === 1'b1 ? n : dn;
                nd += rate_change_done_o === 1'b1;
            end
            check(bn, k ? 3 : 0);
            check(dn, 7);
            check(nd, 1);
        end
        // second reset, then port and register reset values, unmapped read
        rst_i <= 1'b1;
        req <= 3'h0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check({cdr_track_enable_o, serial_divider_o, parallel_divider_a_o,
            parallel_divider_b_o}, {1'b1, 5'h1, 3'h4, 3'h2});
        wb(1'b0, 8'h04, 32'h0);
        check(q, 32'h0010_1001);
        wb(1'b0, 8'h10, 32'h0);
        check(q, 32'h0);
        results();
    end
endmodule // test_rx_rate_cdr_ctrl
`default_nettype wire
